//--- bench/peripheral_interrupt_flags_tb_top.sv
// testbench: flag bank register, event and interrupt tests
`timescale 1ns/1ps
module peripheral_interrupt_flags_tb_top;
    import pif_pkg::*;
    logic sys_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, bclr, irq, last_err;
    logic [23:0] req;
    logic [7:0] ev1, spi, ug, ue, ie, ii, pins;
    logic [3:0] dma, st;
    logic [2:0] sel;
    logic t0, i2rx, i2tx, rising;
    int n_fail = 0;
    int n_checks = 0;
    int n_bc = 0;
    always #12.5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) if (bclr === 1'b1) n_bc++;
    pif_periph_model pm (.sys_clk_in(sys_clk_in), .ev1_out(ev1), .dma_out(dma), .tmr0_out(t0), .i2c_rx_out(i2rx),
        .i2c_tx_out(i2tx), .spi_reg_out(spi), .ugen_out(ug), .uerr_out(ue), .ierr_out(ie), .iflg_out(ii),
        .txrx_out(st), .pins_out(pins), .sel_out(sel), .rising_out(rising));
    pif_flag_bank dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .flags1_event_in(ev1), .dma_event_in(dma),
        .timer_zero_event_in(t0), .ext_pins_in(pins), .ext_irq_pin_select_in(sel), .ext_irq0_rising_in(rising),
        .i2c_rx_event_in(i2rx), .i2c_tx_event_in(i2tx), .spi_int_flag_reg_in(spi), .spi_tx_state_in(st[3]),
        .spi_rx_state_in(st[2]), .uart_general_int_reg_in(ug), .uart_error_int_reg_in(ue),
        .uart_tx_state_in(st[1]), .uart_rx_state_in(st[0]), .i2c_error_reg_in(ie), .i2c_int_flag_reg_in(ii),
        .buffer_clear_out(bclr), .request_out(req), .irq_out(irq));
    ////////////////////////////////////////////////////////////////
    // apb master and comparison
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge sys_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk_in);
        end while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h00000000, r);
        check(name, r, exp);
    endtask
    task automatic end_sim();
        if (n_fail == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic do_reset();
        reset_n_in <= 1'b0;
        repeat (5) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        for (int i = 0; i < 9; i++) rd("reset value", 12'(i * 4), 32'h00000000);
    endtask
    task automatic t_flags1();
        pm.pulse(8'hA5, 4'h0, 1'b0, 1'b0, 1'b0);
        rd("flags1 set", PIF_OFF_FLAGS1, 32'h000000A5);
        wr(PIF_OFF_FLAGS1, 32'h000000FF);
        rd("flags1 write one", PIF_OFF_FLAGS1, 32'h000000A5);
        wr(PIF_OFF_FLAGS1, 32'h0000000F);
        rd("flags1 partial clear", PIF_OFF_FLAGS1, 32'h00000005);
        wr(PIF_OFF_FLAGS1, 32'h00000000);
        rd("flags1 clear", PIF_OFF_FLAGS1, 32'h00000000);
        fork
            wr(PIF_OFF_FLAGS1, 32'h00000000);
            begin
                @(posedge sys_clk_in);
                pm.pulse(8'h80, 4'h0, 1'b0, 1'b0, 1'b0);
            end
        join
        rd("set beats clear", PIF_OFF_FLAGS1, 32'h00000080);
        wr(PIF_OFF_FLAGS1, 32'h00000000);
    endtask
    task automatic t_flags2();
        pm.pulse(8'h00, 4'hF, 1'b0, 1'b0, 1'b0);
        pm.levels(8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 4'b1000);
        rd("flags2 set", PIF_OFF_FLAGS2, 32'h0000006F);
        wr(PIF_OFF_FLAGS2, 32'h00000000);
        rd("flags2 clear", PIF_OFF_FLAGS2, 32'h00000060);
        pm.levels(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 4'b0100);
        wr(PIF_OFF_FLAGS2, 32'h000000FF);
        rd("flags2 follow", PIF_OFF_FLAGS2, 32'h00000010);
    endtask
    task automatic t_flags3();
        pm.pulse(8'h00, 4'h0, 1'b1, 1'b0, 1'b0);
        pm.levels(8'h00, 8'h01, 8'h80, 8'h02, 8'h04, 4'b0011);
        rd("flags3 set", PIF_OFF_FLAGS3, 32'h000000FE);
        wr(PIF_OFF_FLAGS3, 32'h00000000);
        rd("flags3 clear", PIF_OFF_FLAGS3, 32'h0000007E);
        pm.levels(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 4'b0000);
        rd("flags3 follow", PIF_OFF_FLAGS3, 32'h00000000);
    endtask
    task automatic t_i2c();
        pm.pulse(8'h00, 4'h0, 1'b0, 1'b1, 1'b1);
        wr(PIF_OFF_FLAGS2, 32'h00000000);
        wr(PIF_OFF_FLAGS3, 32'h00000000);
        rd("i2c rx kept", PIF_OFF_FLAGS2, 32'h00000080);
        rd("i2c tx kept", PIF_OFF_FLAGS3, 32'h00000001);
        n_bc = 0;
        wr(PIF_OFF_I2C_STATUS1, 32'h00000001);
        repeat (3) @(posedge sys_clk_in);
        check("buffer clear pulses", 32'(n_bc), 32'h00000001);
        rd("i2c rx cleared", PIF_OFF_FLAGS2, 32'h00000000);
        rd("i2c tx cleared", PIF_OFF_FLAGS3, 32'h00000000);
    endtask
    task automatic t_ext();
        pm.pins(8'h00, 3'd3, 1'b1);
        pm.pins(8'h20, 3'd3, 1'b1);
        rd("other pin", PIF_OFF_FLAGS1, 32'h00000000);
        pm.pins(8'h28, 3'd3, 1'b1);
        rd("selected pin rise", PIF_OFF_FLAGS1, 32'h00000001);
        wr(PIF_OFF_FLAGS1, 32'h00000000);
        pm.pins(8'h28, 3'd3, 1'b0);
        rd("no edge on mode change", PIF_OFF_FLAGS1, 32'h00000000);
        pm.pins(8'h20, 3'd3, 1'b0);
        rd("selected pin fall", PIF_OFF_FLAGS1, 32'h00000001);
    endtask
    task automatic t_irq();
        wr(PIF_OFF_IRQ_CLEAR, 32'h00000007);
        rd("status no enable", PIF_OFF_IRQ_STATUS, 32'h00000000);
        wr(PIF_OFF_ENABLE1, 32'h00000001);
        @(negedge sys_clk_in);
        check("request", 32'(req), 32'h00010000);
        rd("status", PIF_OFF_IRQ_STATUS, 32'h00000004);
        wr(PIF_OFF_IRQ_ENABLE, 32'h00000004);
        @(negedge sys_clk_in);
        check("irq raised", 32'(irq), 32'h00000001);
        wr(PIF_OFF_IRQ_ENABLE, 32'h00000000);
        @(negedge sys_clk_in);
        check("irq masked", 32'(irq), 32'h00000000);
        wr(PIF_OFF_FLAGS1, 32'h00000000);
        wr(PIF_OFF_IRQ_CLEAR, 32'h00000004);
        rd("status cleared", PIF_OFF_IRQ_STATUS, 32'h00000000);
        rd("unmapped", 12'h040, 32'h00000000);
        check("unmapped error", 32'(last_err), 32'h00000001);
    endtask
    task automatic t_reset2();
        pm.pins(8'h28, 3'd3, 1'b1);
        pm.pulse(8'hFF, 4'hF, 1'b1, 1'b0, 1'b0);
        do_reset();
        rd("flags1 after reset", PIF_OFF_FLAGS1, 32'h00000000);
        rd("flags2 after reset", PIF_OFF_FLAGS2, 32'h00000000);
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        do_reset();
        t_reset();
        t_flags1();
        t_flags2();
        t_flags3();
        t_i2c();
        t_ext();
        t_irq();
        t_reset2();
        end_sim();
    end
    initial begin
        repeat (4000) @(posedge sys_clk_in);
        n_fail++;
        end_sim();
    end
endmodule

//--- bench/pif_periph_model.sv
// partner: peripheral event sources and peripheral register levels
`timescale 1ns/1ps
module pif_periph_model (
    input wire logic sys_clk_in,
    output logic [7:0] ev1_out = 8'h00,
    output logic [3:0] dma_out = 4'h0,
    output logic tmr0_out = 1'b0,
    output logic i2c_rx_out = 1'b0,
    output logic i2c_tx_out = 1'b0,
    output logic [7:0] spi_reg_out = 8'h00,
    output logic [7:0] ugen_out = 8'h00,
    output logic [7:0] uerr_out = 8'h00,
    output logic [7:0] ierr_out = 8'h00,
    output logic [7:0] iflg_out = 8'h00,
    output logic [3:0] txrx_out = 4'h0,
    output logic [7:0] pins_out = 8'h00,
    output logic [2:0] sel_out = 3'h0,
    output logic rising_out = 1'b1
);
    ////////////////////////////////////////////////////////////////
    // one-cycle event pulses
    task automatic pulse(input logic [7:0] e1, input logic [3:0] d, input logic t0, input logic rx, input logic tx);
        @(posedge sys_clk_in);
        ev1_out <= e1;
        dma_out <= d;
        tmr0_out <= t0;
        i2c_rx_out <= rx;
        i2c_tx_out <= tx;
        @(posedge sys_clk_in);
        ev1_out <= 8'h00;
        dma_out <= 4'h0;
        tmr0_out <= 1'b0;
        i2c_rx_out <= 1'b0;
        i2c_tx_out <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    // peripheral register contents, cleared by peripheral software
    task automatic levels(input logic [7:0] spi, ug, ue, ie, ii, input logic [3:0] st);
        @(posedge sys_clk_in);
        spi_reg_out <= spi;
        ugen_out <= ug;
        uerr_out <= ue;
        ierr_out <= ie;
        iflg_out <= ii;
        txrx_out <= st;
    endtask
    ////////////////////////////////////////////////////////////////
    // external pins and pin select
    task automatic pins(input logic [7:0] p, input logic [2:0] s, input logic r);
        @(posedge sys_clk_in);
        pins_out <= p;
        sel_out <= s;
        rising_out <= r;
    endtask
endmodule

//--- design/pif_flag_bank.sv
// top: peripheral interrupt flag bank with apb slave and interrupt output
`timescale 1ns/1ps
module pif_flag_bank
    import pif_pkg::*;
#(
    parameter int PIN_COUNT = 8
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [7:0] flags1_event_in,
    input wire logic [3:0] dma_event_in,
    input wire logic timer_zero_event_in,
    input wire logic [PIN_COUNT-1:0] ext_pins_in,
    input wire logic [$clog2(PIN_COUNT)-1:0] ext_irq_pin_select_in,
    input wire logic ext_irq0_rising_in,
    input wire logic i2c_rx_event_in,
    input wire logic i2c_tx_event_in,
    input wire logic [7:0] spi_int_flag_reg_in,
    input wire logic spi_tx_state_in,
    input wire logic spi_rx_state_in,
    input wire logic [7:0] uart_general_int_reg_in,
    input wire logic [7:0] uart_error_int_reg_in,
    input wire logic uart_tx_state_in,
    input wire logic uart_rx_state_in,
    input wire logic [7:0] i2c_error_reg_in,
    input wire logic [7:0] i2c_int_flag_reg_in,
    output logic buffer_clear_out,
    output logic [23:0] request_out,
    output logic irq_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [7:0] en1;
        logic [7:0] en2;
        logic [7:0] en3;
        logic [PIF_IRQ_W-1:0] irq_stat;
        logic [PIF_IRQ_W-1:0] irq_en;
        logic i2c_rx;
        logic i2c_tx;
        logic pin_q;
        logic [31:0] rdata;
        logic buf_clr;
    } pif_top_s;
    pif_top_s st;
    pif_top_s next_st;

    pif_flag_if f1 ();
    pif_flag_if f2 ();
    pif_flag_if f3 ();
    pif_sticky_bank u_bank1 (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .port(f1.bank));
    pif_sticky_bank u_bank2 (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .port(f2.bank));
    pif_sticky_bank u_bank3 (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .port(f3.bank));

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    logic acc_w;
    logic acc_r;
    logic lane0;
    logic mapped;
    logic ext_pin;
    logic ext_rise;
    logic [7:0] reg2;
    logic [7:0] reg3;
    logic [2:0] raw_irq;
    logic [31:0] rd_mux;

    assign acc_w = psel_in && penable_in && pwrite_in;
    assign acc_r = psel_in && !penable_in && !pwrite_in;
    assign lane0 = pstrb_in[0];
    assign mapped = hit(paddr_in, PIF_OFF_FLAGS1) || hit(paddr_in, PIF_OFF_FLAGS2)
        || hit(paddr_in, PIF_OFF_FLAGS3) || hit(paddr_in, PIF_OFF_ENABLE1)
        || hit(paddr_in, PIF_OFF_ENABLE2) || hit(paddr_in, PIF_OFF_ENABLE3)
        || hit(paddr_in, PIF_OFF_IRQ_STATUS) || hit(paddr_in, PIF_OFF_IRQ_CLEAR)
        || hit(paddr_in, PIF_OFF_IRQ_ENABLE) || hit(paddr_in, PIF_OFF_I2C_STATUS1);
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;
    assign prdata_out = st.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // external interrupt 0 pin select and edge
    assign ext_pin = ext_pins_in[ext_irq_pin_select_in];
    assign ext_rise = ext_irq0_rising_in ? (ext_pin && !st.pin_q) : (!ext_pin && st.pin_q);

    ////////////////////////////////////////////////////////////////////////////
    // flag sources
    assign f1.set_ev = {flags1_event_in[7:1], flags1_event_in[0] | ext_rise};
    assign f1.sw_mask = PIF_SW_MASK1;
    assign f1.clr = (acc_w && lane0 && hit(paddr_in, PIF_OFF_FLAGS1)) ? ~pwdata_in[7:0] : 8'h00;
    assign f2.set_ev = {4'h0, dma_event_in};
    assign f2.sw_mask = PIF_SW_MASK2;
    assign f2.clr = (acc_w && lane0 && hit(paddr_in, PIF_OFF_FLAGS2)) ? ~pwdata_in[7:0] : 8'h00;
    assign f3.set_ev = {timer_zero_event_in, 7'h00};
    assign f3.sw_mask = PIF_SW_MASK3;
    assign f3.clr = (acc_w && lane0 && hit(paddr_in, PIF_OFF_FLAGS3)) ? ~pwdata_in[7:0] : 8'h00;

    always_comb begin
        reg2 = f2.flags;
        reg2[PIF_B2_I2C_RX] = st.i2c_rx;
        reg2[PIF_B2_SPI_SUM] = |spi_int_flag_reg_in;
        reg2[PIF_B2_SPI_TX] = spi_tx_state_in;
        reg2[PIF_B2_SPI_RX] = spi_rx_state_in;
        reg3 = f3.flags;
        reg3[PIF_B3_UART_SUM] = |uart_general_int_reg_in;
        reg3[PIF_B3_UART_ERR] = |uart_error_int_reg_in;
        reg3[PIF_B3_UART_TX] = uart_tx_state_in;
        reg3[PIF_B3_UART_RX] = uart_rx_state_in;
        reg3[PIF_B3_I2C_ERR] = |i2c_error_reg_in;
        reg3[PIF_B3_I2C_SUM] = |i2c_int_flag_reg_in;
        reg3[PIF_B3_I2C_TX] = st.i2c_tx;
    end

    assign request_out = {f1.flags & st.en1, reg2 & st.en2, reg3 & st.en3};
    assign raw_irq = {|(f1.flags & st.en1), |(reg2 & st.en2), |(reg3 & st.en3)};
    assign irq_out = |(st.irq_stat & st.irq_en);
    assign buffer_clear_out = st.buf_clr;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr_in)
            PIF_OFF_FLAGS1: rd_mux[7:0] = f1.flags;
            PIF_OFF_FLAGS2: rd_mux[7:0] = reg2;
            PIF_OFF_FLAGS3: rd_mux[7:0] = reg3;
            PIF_OFF_ENABLE1: rd_mux[7:0] = st.en1;
            PIF_OFF_ENABLE2: rd_mux[7:0] = st.en2;
            PIF_OFF_ENABLE3: rd_mux[7:0] = st.en3;
            PIF_OFF_IRQ_STATUS: rd_mux[PIF_IRQ_W-1:0] = st.irq_stat;
            PIF_OFF_IRQ_ENABLE: rd_mux[PIF_IRQ_W-1:0] = st.irq_en;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_st = st;
        next_st.pin_q = ext_pin;
        next_st.buf_clr = 1'b0;
        if (acc_r) begin
            next_st.rdata = rd_mux;
        end
        if (acc_w && lane0) begin
            if (hit(paddr_in, PIF_OFF_ENABLE1)) begin
                next_st.en1 = pwdata_in[7:0];
            end
            if (hit(paddr_in, PIF_OFF_ENABLE2)) begin
                next_st.en2 = pwdata_in[7:0];
            end
            if (hit(paddr_in, PIF_OFF_ENABLE3)) begin
                next_st.en3 = pwdata_in[7:0];
            end
            if (hit(paddr_in, PIF_OFF_IRQ_ENABLE)) begin
                next_st.irq_en = pwdata_in[PIF_IRQ_W-1:0];
            end
            if (hit(paddr_in, PIF_OFF_IRQ_CLEAR)) begin
                next_st.irq_stat = st.irq_stat & ~pwdata_in[PIF_IRQ_W-1:0];
            end
            if (hit(paddr_in, PIF_OFF_I2C_STATUS1) && pwdata_in[PIF_BUFFER_CLEAR_BIT]) begin
                next_st.buf_clr = 1'b1;
                next_st.i2c_rx = 1'b0;
                next_st.i2c_tx = 1'b0;
            end
        end
        if (i2c_rx_event_in) begin
            next_st.i2c_rx = 1'b1;
        end
        if (i2c_tx_event_in) begin
            next_st.i2c_tx = 1'b1;
        end
        next_st.irq_stat = next_st.irq_stat | raw_irq;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            st <= '0;
            st.pin_q <= ext_pin;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_buf_write;
        acc_w && lane0 && hit(paddr_in, PIF_OFF_I2C_STATUS1) && pwdata_in[PIF_BUFFER_CLEAR_BIT]
            && !i2c_rx_event_in;
    endsequence
    a_i2c_rx_clear: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        s_buf_write |=> !reg2[PIF_B2_I2C_RX])
        else $error("i2c rx flag not cleared by buffer clear");
    a_i2c_rx_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        reg2[PIF_B2_I2C_RX] && !(acc_w && hit(paddr_in, PIF_OFF_I2C_STATUS1)) |=> reg2[PIF_B2_I2C_RX])
        else $error("i2c rx flag dropped on its own");
    a_spi_summary: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        reg2[PIF_B2_SPI_SUM] == (spi_int_flag_reg_in != 8'h00))
        else $error("spi summary mismatch");
    a_uart_summary: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        reg3[PIF_B3_UART_SUM] == (uart_general_int_reg_in != 8'h00))
        else $error("uart summary mismatch");
    a_uart_error: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        reg3[PIF_B3_UART_ERR] == (uart_error_int_reg_in != 8'h00))
        else $error("uart error mismatch");
    a_i2c_error: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        reg3[PIF_B3_I2C_ERR] == (i2c_error_reg_in != 8'h00))
        else $error("i2c error mismatch");
    a_i2c_summary: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        reg3[PIF_B3_I2C_SUM] == (i2c_int_flag_reg_in != 8'h00))
        else $error("i2c summary mismatch");
    a_tx_ignores_sw: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        reg3[PIF_B3_UART_TX] == uart_tx_state_in && reg2[PIF_B2_SPI_TX] == spi_tx_state_in)
        else $error("tx flag not following peripheral");
    a_event_sets: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        timer_zero_event_in |=> reg3[PIF_B3_TMR0])
        else $error("timer zero event lost");
    a_dma_sticky: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        dma_event_in[0] ##1 !(acc_w && hit(paddr_in, PIF_OFF_FLAGS2)) [*2] |-> reg2[0])
        else $error("dma flag not sticky");
    a_request_gate: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        request_out[23] == (f1.flags[7] && st.en1[7]))
        else $error("request not flag and enable");
    a_reset_zero: assert property (@(posedge sys_clk_in) disable iff (1'b0)
        !reset_n_in |=> f1.flags == PIF_FLAGS_RESET && !reg3[PIF_B3_TMR0])
        else $error("flags not zero after reset");

    sequence s_clr_flag(logic [11:0] off, int b, logic ev);
        acc_w && lane0 && hit(paddr_in, off) && !pwdata_in[b] && !ev;
    endsequence
    sequence s_tx_clear;
        acc_w && lane0 && hit(paddr_in, PIF_OFF_I2C_STATUS1)
            && pwdata_in[PIF_BUFFER_CLEAR_BIT] && !i2c_tx_event_in;
    endsequence
    sequence s_pin_rise;
        (ext_irq0_rising_in && !ext_pin) ##1 (ext_irq0_rising_in && ext_pin);
    endsequence
    sequence s_pin_fall;
        (!ext_irq0_rising_in && ext_pin) ##1 (!ext_irq0_rising_in && !ext_pin);
    endsequence

    a_flags1_clear: assert property (
        s_clr_flag(PIF_OFF_FLAGS1, 7, flags1_event_in[7]) |=> !f1.flags[7])
        else $error("flags1 bit not cleared");
    a_dma_clear: assert property (
        s_clr_flag(PIF_OFF_FLAGS2, 0, dma_event_in[0]) |=> !reg2[0])
        else $error("dma flag not cleared");
    a_tmr0_clear: assert property (
        s_clr_flag(PIF_OFF_FLAGS3, PIF_B3_TMR0, timer_zero_event_in) |=> !reg3[PIF_B3_TMR0])
        else $error("timer zero flag not cleared");
    a_ones_keep: assert property (
        acc_w && hit(paddr_in, PIF_OFF_FLAGS1) && pwdata_in[7] && f1.flags[7] |=> f1.flags[7])
        else $error("write of one cleared a flag");
    a_dma_keep: assert property (
        acc_w && hit(paddr_in, PIF_OFF_FLAGS2) && pwdata_in[3] && reg2[3] |=> reg2[3])
        else $error("dma flag lost on write of one");

    a_flags1_set: assert property (
        flags1_event_in[6] |=> f1.flags[6])
        else $error("flags1 event lost");
    a_dma_set: assert property (
        dma_event_in[3] |=> reg2[3])
        else $error("dma event lost");
    a_rx_set: assert property (
        i2c_rx_event_in |=> reg2[PIF_B2_I2C_RX])
        else $error("i2c rx event lost");
    a_tx_set: assert property (
        i2c_tx_event_in |=> reg3[PIF_B3_I2C_TX])
        else $error("i2c tx event lost");
    a_rx_follow: assert property (
        reg2[PIF_B2_SPI_RX] == spi_rx_state_in && reg3[PIF_B3_UART_RX] == uart_rx_state_in)
        else $error("rx flag not following peripheral");

    a_i2c_tx_clear: assert property (
        s_tx_clear |=> !reg3[PIF_B3_I2C_TX])
        else $error("i2c tx flag not cleared by buffer clear");
    a_i2c_tx_hold: assert property (
        reg3[PIF_B3_I2C_TX] && !(acc_w && hit(paddr_in, PIF_OFF_I2C_STATUS1)) |=> reg3[PIF_B3_I2C_TX])
        else $error("i2c tx flag dropped on its own");
    a_buf_pulse: assert property (
        s_buf_write |=> buffer_clear_out)
        else $error("buffer clear not pulsed");
    a_buf_single: assert property (
        buffer_clear_out |=> !buffer_clear_out)
        else $error("buffer clear longer than one cycle");

    a_ext_rise: assert property (
        s_pin_rise |=> f1.flags[0])
        else $error("rising edge of selected pin lost");
    a_ext_fall: assert property (
        s_pin_fall |=> f1.flags[0])
        else $error("falling edge of selected pin lost");
    a_ext_quiet: assert property (
        ext_pin == st.pin_q && !flags1_event_in[0] && !f1.flags[0] |=> !f1.flags[0])
        else $error("ext flag set without edge");

    a_status_f1: assert property (
        |(f1.flags & st.en1) |=> st.irq_stat[2])
        else $error("flags1 request not latched");
    a_status_f2: assert property (
        |(reg2 & st.en2) |=> st.irq_stat[1])
        else $error("flags2 request not latched");
    a_status_f3: assert property (
        |(reg3 & st.en3) |=> st.irq_stat[0])
        else $error("flags3 request not latched");
    a_masked_quiet: assert property (
        st.en3 == 8'h00 |-> request_out[7:0] == 8'h00)
        else $error("request without enable");
    a_en_write: assert property (
        acc_w && lane0 && hit(paddr_in, PIF_OFF_ENABLE1) |=> st.en1 == $past(pwdata_in[7:0]))
        else $error("enable write lost");
    a_irq_clear: assert property (
        acc_w && lane0 && hit(paddr_in, PIF_OFF_IRQ_CLEAR) && pwdata_in[2] && !raw_irq[2] |=> !st.irq_stat[2])
        else $error("irq status not cleared");
    a_reset_rest: assert property (disable iff (1'b0)
        !reset_n_in |=> f2.flags == PIF_FLAGS_RESET && !st.i2c_rx && !st.i2c_tx && st.en1 == 8'h00)
        else $error("state not zero after reset");
endmodule

//--- design/pif_flag_if.sv
// interface: one flag byte with its hardware set and software clear terms
`timescale 1ns/1ps
interface pif_flag_if;
    logic [7:0] set_ev;
    logic [7:0] clr;
    logic [7:0] sw_mask;
    logic [7:0] flags;
    modport bank (input set_ev, input clr, input sw_mask, output flags);
    modport ctrl (output set_ev, output clr, output sw_mask, input flags);
endinterface

//--- design/pif_pkg.sv
// package: register map, field positions and reset values of the flag bank
package pif_pkg;
    localparam logic [11:0] PIF_OFF_FLAGS1 = 12'h000;
    localparam logic [11:0] PIF_OFF_FLAGS2 = 12'h004;
    localparam logic [11:0] PIF_OFF_FLAGS3 = 12'h008;
    localparam logic [11:0] PIF_OFF_ENABLE1 = 12'h00C;
    localparam logic [11:0] PIF_OFF_ENABLE2 = 12'h010;
    localparam logic [11:0] PIF_OFF_ENABLE3 = 12'h014;
    localparam logic [11:0] PIF_OFF_IRQ_STATUS = 12'h018;
    localparam logic [11:0] PIF_OFF_IRQ_CLEAR = 12'h01C;
    localparam logic [11:0] PIF_OFF_IRQ_ENABLE = 12'h020;
    localparam logic [11:0] PIF_OFF_I2C_STATUS1 = 12'h024;
    localparam logic [7:0] PIF_FLAGS_RESET = 8'h00;
    // writable (software-clearable) bits of each flag register
    localparam logic [7:0] PIF_SW_MASK1 = 8'hFF;
    localparam logic [7:0] PIF_SW_MASK2 = 8'h0F;
    localparam logic [7:0] PIF_SW_MASK3 = 8'h80;
    // flags2 bit positions
    localparam int PIF_B2_I2C_RX = 7;
    localparam int PIF_B2_SPI_SUM = 6;
    localparam int PIF_B2_SPI_TX = 5;
    localparam int PIF_B2_SPI_RX = 4;
    // flags3 bit positions
    localparam int PIF_B3_TMR0 = 7;
    localparam int PIF_B3_UART_SUM = 6;
    localparam int PIF_B3_UART_ERR = 5;
    localparam int PIF_B3_UART_TX = 4;
    localparam int PIF_B3_UART_RX = 3;
    localparam int PIF_B3_I2C_ERR = 2;
    localparam int PIF_B3_I2C_SUM = 1;
    localparam int PIF_B3_I2C_TX = 0;
    // buffer_clear_bit position in the i2c_status_one_reg register
    localparam int PIF_BUFFER_CLEAR_BIT = 0;
    localparam logic [1:0] PIF_IRQ_W = 2'd3;
endpackage

//--- design/pif_sticky_bank.sv
// module: eight sticky flags, hardware set beats software clear
`timescale 1ns/1ps
module pif_sticky_bank
    import pif_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    pif_flag_if.bank port
);
    typedef struct packed {
        logic [7:0] flags;
    } pif_bank_s;
    pif_bank_s st;
    pif_bank_s next_st;
    always_comb begin
        next_st = st;
        // set wins over clear; only writable bits clear
        next_st.flags = (st.flags & ~(port.clr & port.sw_mask)) | port.set_ev;
    end
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign port.flags = st.flags;
    a_flag_holds: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        st.flags[0] && !(port.clr[0] && port.sw_mask[0]) |=> st.flags[0])
        else $error("sticky flag dropped without clear");
    a_set_wins: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        port.set_ev[7] && port.clr[7] |=> st.flags[7])
        else $error("set lost against clear");
endmodule
